// ---- dv/tb_top.sv ----
`timescale 1ns/1ns
`define CHK(nm, e, s) begin samplesChecked++; if ((s) !== (e)) begin \
    errTotal++; $display("MISMATCH %s exp %h got %h", nm, e, s); end end
// drives the trap unit over apb and trap strobes, checks its outputs
module tb_top;
    logic core_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, rd;
    logic trapReq = 0, instrUrgentErr = 0, autoUrgentErr = 0, er;
    logic fetchAccessErr = 0, dataAccessErr = 0, watchdogTimeout = 0;
    logic [57:0] errIndication = 58'h0;
    logic [1:0] endMethod = 2'h0;
    logic [8:0] trapType = 9'h15A;
    logic retireReturn = 0, curStateFault = 0, curPcFault = 0;
    logic [12:0] curState = 13'h0000;
    logic [63:0] curPc = 64'h0000_0000_0040_1000;
    logic [63:0] curNpc = 64'h0000_0000_0040_1004;
    logic ccrFault = 0, fsrFault = 0, gsrFault = 0, tickFault = 0;
    logic cmpFault = 0, curNpcFault = 0;
    logic [4:0] winFault = 5'h00;
    logic [63:0] tba = 64'h0000_0012_ABCD_8000, expSt;
    logic [63:0] rstv = 64'h0000_00FF_F000_0000;
    wire [31:0] prdata;
    wire pready, pslverr, trapTakenR, haltedR, recoveryR, handlerActiveR;
    wire [2:0] trapLevelR;
    wire [63:0] pcR, npcR, savedPcR, savedNpcR, tickNewR, cmpNewR, statusR;
    wire [12:0] stateR, savedStateR;
    wire savedStateFaultR, savedPcFaultR, savedNpcFaultR, weakDetectR;
    wire ccrZeroR, fsrZeroR, gsrZeroR, tickWrR, cmpWrR;
    wire [4:0] winZeroR;
    integer errTotal = 0, samplesChecked = 0, i;

    uetu_trap_unit dut (.*, .recoveryExit(1'b0), .tickVal(64'h0),
        .cmpVal(64'h0));

    // 25 MHz core clock
    always #20 core_clk = ~core_clk;

    // verdict and end of run
    task tallyAndFinish();
        $display("checks %0d mismatches %0d", samplesChecked, errTotal);
        if (errTotal == 0 && samplesChecked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // one apb transfer; read data and error taken at the ready edge
    task apb(input w, input [7:0] a, input [31:0] wd);
        @(posedge core_clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1;
        @(posedge core_clk);
        while (pready !== 1'b1)
            @(posedge core_clk);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    // one-cycle strobe of causes {data, fetch, auto, instr} and return
    task pulse(input [3:0] c, input r);
        @(posedge core_clk);
        trapReq <= |c;
        {dataAccessErr, fetchAccessErr, autoUrgentErr, instrUrgentErr} <= c;
        retireReturn <= r;
        @(posedge core_clk);
        trapReq <= 0;
        {dataAccessErr, fetchAccessErr, autoUrgentErr, instrUrgentErr} <= 0;
        retireReturn <= 0;
        #1;
    endtask

    // vector table slot for the current base and trap type
    function [63:0] tgt(input nz);
        tgt = {tba[63:15], nz, trapType, 5'h00};
    endfunction

    initial begin
        #80000;
        errTotal++;
        tallyAndFinish();
    end

    initial begin
        repeat (8) @(posedge core_clk);
        sys_rst <= 0;
        // registers, unmapped place and read-only status
        apb(0, 8'h20, 32'h0000_0000);
        `CHK("unmapped", 33'h1_0000_0000, {er, rd})
        apb(1, 8'h00, 32'hFFFF_FFFF);
        apb(1, 8'h10, tba[31:0]);
        apb(1, 8'h14, tba[63:32]);
        apb(1, 8'h18, rstv[31:0]);
        apb(1, 8'h1C, rstv[63:32]);
        apb(0, 8'h14, 32'h0000_0000);
        `CHK("base hi", tba[63:32], rd)
        apb(0, 8'h00, 32'h0000_0000);
        `CHK("status ro", 32'h0000_0000, rd)
        // first single trap with condition codes, float status, one window, counter, compare and pc faulty
        curState <= 13'h1FFB;
        {ccrFault, fsrFault, tickFault, cmpFault, curPcFault} <= 5'h1F;
        winFault <= 5'h02;
        endMethod <= 2'h1;
        errIndication <= 58'h2AA_AAAA_5555_5555;
        pulse(4'h1, 0);
        expSt = {errIndication, 6'h00} | 64'h0000_0000_000A_0010;
        `CHK("pc", tgt(0), pcR)
        `CHK("level", 3'h1, trapLevelR)
        `CHK("saved", {13'h1FFB, curPc, curNpc, 3'h2}, {savedStateR, savedPcR,
            savedNpcR, savedStateFaultR, savedPcFaultR, savedNpcFaultR})
        `CHK("zeroes", 8'hC2, {ccrZeroR, fsrZeroR, gsrZeroR, winZeroR})
        `CHK("cmp", {1'b1, 64'h8000_0000_0000_0000}, {cmpWrR, cmpNewR})
        `CHK("status", expSt, statusR)
        {ccrFault, fsrFault, tickFault, cmpFault, curPcFault} <= 5'h00;
        winFault <= 5'h00;
        errIndication <= 58'h0;
        apb(0, 8'h04, 32'h0000_0000);
        `CHK("status hi", expSt[63:32], rd)
        apb(0, 8'h08, 32'h0000_0000);
        `CHK("control", 32'h0000_0001, rd)
        // two multiple traps, causes gather and hold
        pulse(4'hC, 0);
        `CHK("multi", {64'h6 | expSt, 1'b1, tgt(1)}, {statusR, weakDetectR, pcR})
        pulse(4'h1, 0);
        `CHK("multi iue", 64'h7 | expSt, statusR)
        pulse(4'h0, 1);
        `CHK("return", 4'h2, {handlerActiveR, trapLevelR})
        // single traps over every end method code
        for (i = 0; i < 3; i++) begin
            endMethod <= (i == 2) ? 2'h3 : i[1:0];
            curState <= (i == 1) ? 13'h0004 : 13'h0000;
            curStateFault <= (i == 2);
            watchdogTimeout <= (i == 2);
            gsrFault <= 1;
            pulse(4'h2, 0);
            `CHK("low bits", {(i == 2) ? 2'h3 : i[1:0], i != 0, 3'h0}, statusR[5:0])
            `CHK("fp flag", 2'h3, {statusR[17], gsrZeroR})
            pulse(4'h0, 1);
        end
        {gsrFault, curStateFault, watchdogTimeout} <= 3'h0;
        // climb into recovery, then halt at the top level
        pulse(4'h2, 0);
        pulse(4'h4, 0);
        pulse(4'h8, 0);
        `CHK("recovery", {1'b1, rstv + 64'hA0}, {recoveryR, pcR})
        pulse(4'h8, 0);
        `CHK("halt", 5'h0D, {trapTakenR, haltedR, trapLevelR})
        apb(0, 8'h0C, 32'h0000_0000);
        `CHK("level reg", 32'h0000_0085, rd)
        apb(1, 8'h08, 32'h0000_0002);
        apb(0, 8'h08, 32'h0000_0000);
        `CHK("weak clear", 32'h0000_0001, rd)
        tallyAndFinish();
    end
endmodule

// ---- dv/uetu_monitor.sv ----
`timescale 1ns/1ns
// port-level checks of trap decisions, levels and rewrites
module uetu_monitor #(
    parameter LEVEL_W = 3, // level width
    parameter [2:0] LEVEL_MAX = 3'h5 // top level
) (
    input wire core_clk, // clock
    input wire sys_rst, // reset
    input wire trapReq, // strobe
    input wire instrUrgentErr, // cause
    input wire autoUrgentErr, // cause
    input wire fetchAccessErr, // cause
    input wire dataAccessErr, // cause
    input wire watchdogTimeout, // time-out
    input wire [1:0] endMethod, // end method
    input wire retireReturn, // return done
    input wire [12:0] curState, // old state
    input wire curStateFault, // state fault
    input wire [4:0] winFault, // window faults
    input wire tickFault, // counter fault
    input wire trapTakenR, // taken pulse
    input wire haltedR, // halted
    input wire recoveryR, // recovery
    input wire [LEVEL_W-1:0] trapLevelR, // level
    input wire [63:0] pcR, // new pc
    input wire [63:0] npcR, // new next pc
    input wire [12:0] stateR, // new state
    input wire [4:0] winZeroR, // window zero
    input wire tickWrR, // counter write
    input wire [63:0] tickNewR, // counter value
    input wire [63:0] statusR, // status
    input wire handlerActiveR, // handler flag
    input wire weakDetectR // weak flag
);
    // trap classes at the strobe, before the level limit
    wire isSingle = trapReq && !handlerActiveR && !haltedR
        && (instrUrgentErr || autoUrgentErr);
    wire isMulti = trapReq && handlerActiveR && !haltedR
        && (instrUrgentErr || fetchAccessErr || dataAccessErr);

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // accepted traps, and the one abandoned at the top level
    sequence singleTake;
        isSingle && trapLevelR != LEVEL_MAX;
    endsequence
    sequence multiTake;
        isMulti && trapLevelR != LEVEL_MAX;
    endsequence
    sequence topTrap;
        (isSingle || isMulti) && trapLevelR == LEVEL_MAX && !retireReturn;
    endsequence

    handler_set_a:
        assert property (singleTake |=> handlerActiveR)
        else $error("handler flag not set");
    handler_clear_a:
        assert property (retireReturn && !trapReq |=> !handlerActiveR)
        else $error("handler flag not cleared");
    weak_set_a:
        assert property (multiTake |=> weakDetectR)
        else $error("weak flag not set");
    top_halt_a:
        assert property (topTrap |=> haltedR && !trapTakenR
            && $stable(trapLevelR))
        else $error("trap at top level not abandoned");
    level_step_a:
        assert property ((singleTake or multiTake) ##0 !retireReturn
            |=> trapTakenR && trapLevelR == $past(trapLevelR) + 1'b1)
        else $error("level not stepped by one");
    recovery_entry_a:
        assert property ((singleTake or multiTake) ##0 !recoveryR
            && trapLevelR == LEVEL_MAX - 1 |=> recoveryR)
        else $error("recovery not entered");
    npc_step_a:
        assert property (trapTakenR |-> npcR == pcR + 64'h0000_0000_0000_0004)
        else $error("next pc not target plus four");
    state_fixed_a:
        assert property (trapTakenR
            |-> stateR[11:0] == {6'h00, recoveryR, 5'h15})
        else $error("state not rewritten");
    single_status_a:
        assert property (singleTake |=> statusR[2:0] == 3'h0
            && statusR[3] == ($past(curStateFault) || $past(curState[2]))
            && ($past(watchdogTimeout) || statusR[5:4] == $past(endMethod)))
        else $error("single trap status low bits wrong");
    multi_cause_a:
        assert property (multiTake |=> statusR[63:3] == $past(statusR[63:3])
            && statusR[2:0] == ($past(statusR[2:0]) | {$past(dataAccessErr),
            $past(fetchAccessErr), $past(instrUrgentErr)}))
        else $error("multiple trap status wrong");
    window_zero_a:
        assert property (singleTake ##0 (|winFault)
            |=> winZeroR == $past(winFault) && statusR[19])
        else $error("window rewrite wrong");
    tick_rewrite_a:
        assert property ((singleTake or multiTake) ##0 tickFault
            |=> tickWrR && tickNewR == 64'h8000_0000_0000_0000)
        else $error("counter rewrite wrong");
endmodule

bind uetu_trap_unit uetu_monitor #(
    .LEVEL_W(LEVEL_W),
    .LEVEL_MAX(LEVEL_MAX)
) mon (.*);

// ---- hw/uetu_apb_regs.v ----
`timescale 1ns/1ns
`include "uetu_regs.vh"
// apb slave: status read-back, vector bases, weak flag clear
module uetu_apb_regs (
    input wire core_clk, // core clock
    input wire sys_rst, // async reset, high
    input wire psel, // apb select
    input wire penable, // apb enable
    input wire pwrite, // apb direction
    input wire [7:0] paddr, // apb byte address
    input wire [31:0] pwdata, // apb write data
    output reg [31:0] prdata, // apb read data
    output wire pready, // apb ready
    output wire pslverr, // apb error on unmapped
    input wire [63:0] status, // urgent error status
    input wire [1:0] errCtl, // handler and weak flags
    input wire [7:0] levelInfo, // trap level and core state
    output reg [63:0] tbaR, // trap table base
    output reg [63:0] rstvR, // reset vector base
    output wire weakClr // weak flag clear pulse
);
    reg hit;
    reg [31:0] rdVal;
    wire wrAcc;
    // decode and read mux
    always @* begin
        hit = 1'b1;
        rdVal = 32'h0000_0000;
        if (paddr == `UETU_OFS_STAT_LO) begin
            rdVal = status[31:0];
        end else if (paddr == `UETU_OFS_STAT_HI) begin
            rdVal = status[63:32];
        end else if (paddr == `UETU_OFS_ERRCTL) begin
            rdVal = {30'h0000_0000, errCtl};
        end else if (paddr == `UETU_OFS_LEVEL) begin
            rdVal = {24'h00_0000, levelInfo};
        end else if (paddr == `UETU_OFS_TBA_LO) begin
            rdVal = tbaR[31:0];
        end else if (paddr == `UETU_OFS_TBA_HI) begin
            rdVal = tbaR[63:32];
        end else if (paddr == `UETU_OFS_RSTV_LO) begin
            rdVal = rstvR[31:0];
        end else if (paddr == `UETU_OFS_RSTV_HI) begin
            rdVal = rstvR[63:32];
        end else begin
            hit = 1'b0;
        end
    end
    assign pready = 1'b1; // no wait states
    assign pslverr = psel & penable & ~hit;
    assign wrAcc = psel & penable & pwrite;
    assign weakClr = wrAcc & (paddr == `UETU_OFS_ERRCTL)
                     & pwdata[`UETU_CTL_WEAK];
    // writable bases and read data capture
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tbaR <= {`UETU_TBA_RESET, `UETU_TBA_RESET};
            rstvR <= {`UETU_RSTV_RESET, `UETU_RSTV_RESET};
            prdata <= 32'h0000_0000;
        end else begin
            if (psel & ~penable) begin
                prdata <= rdVal; // captured in setup cycle
            end
            if (wrAcc & (paddr == `UETU_OFS_TBA_LO)) begin
                tbaR[31:0] <= pwdata;
            end
            if (wrAcc & (paddr == `UETU_OFS_TBA_HI)) begin
                tbaR[63:32] <= pwdata;
            end
            if (wrAcc & (paddr == `UETU_OFS_RSTV_LO)) begin
                rstvR[31:0] <= pwdata;
            end
            if (wrAcc & (paddr == `UETU_OFS_RSTV_HI)) begin
                rstvR[63:32] <= pwdata;
            end
        end
    end
endmodule

// ---- hw/uetu_regs.vh ----
`ifndef UETU_REGS_VH
`define UETU_REGS_VH
// apb register byte offsets
`define UETU_OFS_STAT_LO 8'h00
`define UETU_OFS_STAT_HI 8'h04
`define UETU_OFS_ERRCTL 8'h08
`define UETU_OFS_LEVEL 8'h0C
`define UETU_OFS_TBA_LO 8'h10
`define UETU_OFS_TBA_HI 8'h14
`define UETU_OFS_RSTV_LO 8'h18
`define UETU_OFS_RSTV_HI 8'h1C
// error control bits
`define UETU_CTL_WEAK 1
// urgent error status fields
`define UETU_ST_MULTI_FETCHURG 0
`define UETU_ST_MULTI_FETCH 1
`define UETU_ST_MULTI_DATA 2
`define UETU_ST_SUPER 3
`define UETU_ST_ENDM_LO 4
`define UETU_ST_ENDM_HI 5
`define UETU_ST_IND_LO 6
`define UETU_ST_IND_HI 63
`define UETU_ST_FPFLT 17
`define UETU_ST_STFLT 19
`define UETU_ST_RESET 64'h0000_0000_0000_0000
// end method codes
`define UETU_ENDM_PRECISE 2'h0
`define UETU_ENDM_RETRY 2'h1
`define UETU_ENDM_NORETRY 2'h3
// processor state bits set on a trap
`define UETU_PS_ALTG 0
`define UETU_PS_SUPER 2
`define UETU_PS_FPU 4
`define UETU_PS_RED 5
// trap vector pieces
`define UETU_RED_VEC_OFS 64'h0000_0000_0000_00A0
`define UETU_NPC_STEP 64'h0000_0000_0000_0004
// cycle counter rewrite values and base register reset values
`define UETU_TICK_NPT_SET 64'h8000_0000_0000_0000
`define UETU_CMP_DIS_SET 64'h8000_0000_0000_0000
`define UETU_TBA_RESET 32'h0000_0000
`define UETU_RSTV_RESET 32'h0000_0000
`endif

// ---- hw/uetu_target_calc.v ----
`timescale 1ns/1ns
`include "uetu_regs.vh"
// trap target: vector table slot, or fixed slot off the reset vector
module uetu_target_calc (
    input wire [63:0] trapBase, // trap table base
    input wire [63:0] resetBase, // reset vector base
    input wire [8:0] trapType, // trap type code
    input wire levelNonZero, // trap level above zero before trap
    input wire recovery, // recovery mode taken for this trap
    output wire [63:0] target // computed trap address
);
    wire [63:0] tableAddr;
    // table slot from base, level half and type
    assign tableAddr = {trapBase[63:15], levelNonZero, trapType, 5'h0_0};
    assign target = recovery ? (resetBase + `UETU_RED_VEC_OFS)
                             : tableAddr; // see RULE8
endmodule

// ---- hw/uetu_trap_unit.v ----
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ns
`include "uetu_regs.vh"
// Operation
// RULE1 - end method undefined after watchdog time-out
// RULE2 - single trap: status bit3 copies supervisor flag
// RULE3 - bits 2..0 record multiple-trap causes
// RULE4 - single trap: handler idle, urgent error
// RULE5 - multiple trap: handler busy, urgent/access error
// RULE6 - level at max: halt, abandon trap
// RULE7 - execution at max minus one: enter recovery
// RULE8 - target from table, or reset base plus A0
// RULE9 - state, then target, then level increment
// RULE10 - save pre-trap state, pc, next pc
// RULE11 - write fixed processor state on trap
// RULE12 - pc gets target, next pc target plus 4
// RULE13 - zero faulty condition, float, graphics status
// RULE14 - zero faulty window registers, flag it
// RULE15 - rewrite faulty cycle counter and compare
// RULE16 - full rewrite clears that register's error
// RULE17 - single trap updates indication bits 63..6
// RULE18 - single trap writes end method field
// RULE19 - single trap sets handler active
// RULE20 - multiple trap sets weak detection flag
// RULE21 - return instruction clears handler active
// RULE22 - end method codes 00, 01, 11
// RULE23 - float fault flag at status bit 17
// RULE24 - state fault flag at status bit 19
// RULE25 - several causes set together in one update
module uetu_trap_unit #(
    parameter LEVEL_W = 3, // trap level width
    parameter [2:0] LEVEL_MAX = 3'h5 // highest trap level
) (
    input wire core_clk, // core clock, 25 MHz
    input wire sys_rst, // async reset, high
    input wire psel, // apb select
    input wire penable, // apb enable
    input wire pwrite, // apb direction
    input wire [7:0] paddr, // apb byte address
    input wire [31:0] pwdata, // apb write data
    output wire [31:0] prdata, // apb read data
    output wire pready, // apb ready
    output wire pslverr, // apb error
    input wire trapReq, // error detection strobe
    input wire instrUrgentErr, // instruction urgent error seen
    input wire autoUrgentErr, // autonomous urgent error seen
    input wire fetchAccessErr, // instruction access error seen
    input wire dataAccessErr, // data access error seen
    input wire watchdogTimeout, // watchdog time-out seen
    input wire [57:0] errIndication, // detected error indications
    input wire [1:0] endMethod, // end method of trapped instr
    input wire [8:0] trapType, // trap type code
    input wire retireReturn, // return instruction completed
    input wire recoveryExit, // core leaves recovery mode
    input wire [12:0] curState, // pre-trap processor state
    input wire curStateFault, // processor state holds fault
    input wire [63:0] curPc, // pre-trap pc
    input wire curPcFault, // pc holds fault
    input wire [63:0] curNpc, // pre-trap next pc
    input wire curNpcFault, // next pc holds fault
    input wire ccrFault, // condition codes hold fault
    input wire fsrFault, // float status holds fault
    input wire gsrFault, // graphics status holds fault
    input wire [4:0] winFault, // window registers hold fault
    input wire tickFault, // cycle counter holds fault
    input wire [63:0] tickVal, // cycle counter value
    input wire cmpFault, // cycle compare holds fault
    input wire [63:0] cmpVal, // cycle compare value
    output reg trapTakenR, // trap taken pulse
    output reg haltedR, // halted fault state
    output reg recoveryR, // recovery mode state
    output reg [LEVEL_W-1:0] trapLevelR, // trap level
    output reg [63:0] pcR, // new pc
    output reg [63:0] npcR, // new next pc
    output reg [12:0] stateR, // new processor state
    output reg [12:0] savedStateR, // saved processor state
    output reg savedStateFaultR, // saved state carries fault
    output reg [63:0] savedPcR, // saved pc
    output reg savedPcFaultR, // saved pc carries fault
    output reg [63:0] savedNpcR, // saved next pc
    output reg savedNpcFaultR, // saved next pc carries fault
    output reg ccrZeroR, // zero condition codes pulse
    output reg fsrZeroR, // zero float status pulse
    output reg gsrZeroR, // zero graphics status pulse
    output reg [4:0] winZeroR, // zero window registers pulse
    output reg tickWrR, // cycle counter write pulse
    output reg [63:0] tickNewR, // cycle counter new value
    output reg cmpWrR, // cycle compare write pulse
    output reg [63:0] cmpNewR, // cycle compare new value
    output reg [63:0] statusR, // urgent error status
    output reg handlerActiveR, // urgent handler running
    output reg weakDetectR // weak detection state
);
    localparam [1:0] ST_EXEC = 2'h0;
    localparam [1:0] ST_RECOV = 2'h1;
    localparam [1:0] ST_HALT = 2'h2;
    reg [1:0] coreSt_r;
    reg [1:0] coreSt_nxt;
    reg [LEVEL_W-1:0] level_nxt;
    reg [63:0] status_nxt;
    reg [12:0] newState;
    reg enterRecov;
    wire single;
    wire multi;
    wire take;
    wire abandon;
    wire proceed;
    wire useRecov;
    wire [63:0] target;
    wire [63:0] tbaR;
    wire [63:0] rstvR;
    wire weakClr;
    wire fpZero;
    wire stZero;
    wire [2:0] causeSet;
    // register access
    uetu_apb_regs uRegs (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .status(statusR),
        .errCtl({weakDetectR, handlerActiveR}),
        .levelInfo({haltedR, recoveryR, 3'h0, trapLevelR}),
        .tbaR(tbaR),
        .rstvR(rstvR),
        .weakClr(weakClr)
    );
    // trap kind; halted core takes no further traps
    assign single = trapReq & ~handlerActiveR
                    & (instrUrgentErr | autoUrgentErr); // see RULE4
    assign multi = trapReq & handlerActiveR
                   & (instrUrgentErr | fetchAccessErr
                      | dataAccessErr); // see RULE5
    assign take = (single | multi) & (coreSt_r != ST_HALT);
    assign abandon = take & (trapLevelR == LEVEL_MAX); // see RULE6
    assign proceed = take & ~abandon;
    // state transition first, then level increment
    always @* begin
        coreSt_nxt = coreSt_r;
        level_nxt = trapLevelR;
        enterRecov = 1'b0;
        case (coreSt_r)
            ST_EXEC: begin
                if (abandon) begin
                    coreSt_nxt = ST_HALT; // see RULE6
                end else if (proceed
                    && trapLevelR == LEVEL_MAX - 3'h1) begin
                    coreSt_nxt = ST_RECOV; // see RULE7
                    enterRecov = 1'b1;
                end
            end
            ST_RECOV: begin
                if (abandon) begin
                    coreSt_nxt = ST_HALT; // see RULE6
                end else if (recoveryExit & ~proceed) begin
                    coreSt_nxt = ST_EXEC;
                end
            end
            ST_HALT: begin
                coreSt_nxt = ST_HALT;
            end
            default: begin
                coreSt_nxt = ST_EXEC;
            end
        endcase
        if (proceed) begin
            level_nxt = trapLevelR + 3'h1; // see RULE9
        end else if (retireReturn && trapLevelR != 3'h0
                     && coreSt_r != ST_HALT) begin
            level_nxt = trapLevelR - 3'h1;
        end
    end
    // target uses the state chosen above, see RULE9
    assign useRecov = (coreSt_r == ST_RECOV) | enterRecov;
    uetu_target_calc uTarget (
        .trapBase(tbaR),
        .resetBase(rstvR),
        .trapType(trapType),
        .levelNonZero(trapLevelR != 3'h0),
        .recovery(useRecov),
        .target(target)
    );
    // fixed processor state written on every taken trap, not on one abandoned at the top level
    always @* begin
        newState = 13'h0000; // mm, byte order, others zero
        newState[`UETU_PS_ALTG] = 1'b1; // see RULE11
        newState[`UETU_PS_SUPER] = 1'b1;
        newState[`UETU_PS_FPU] = 1'b1;
        newState[`UETU_PS_RED] = useRecov;
    end
    // faulty register rewrites also mark status on single trap
    assign fpZero = fsrFault | gsrFault; // see RULE13
    assign stZero = |winFault; // see RULE14
    assign causeSet = {dataAccessErr, fetchAccessErr,
                       instrUrgentErr}; // see RULE25
    // status update
    always @* begin
        status_nxt = statusR;
        if (proceed & single) begin
            status_nxt[`UETU_ST_IND_HI:`UETU_ST_IND_LO] =
                errIndication; // see RULE17
            if (fpZero) begin
                status_nxt[`UETU_ST_FPFLT] = 1'b1; // see RULE23
            end
            if (stZero | curStateFault | curPcFault
                | curNpcFault) begin
                status_nxt[`UETU_ST_STFLT] = 1'b1; // see RULE24
            end
            // watchdog leaves the code meaningless, see RULE1
            status_nxt[`UETU_ST_ENDM_HI:`UETU_ST_ENDM_LO] =
                watchdogTimeout ? `UETU_ENDM_NORETRY // see RULE22
                                : endMethod; // see RULE18
            status_nxt[`UETU_ST_SUPER] = curStateFault
                | curState[`UETU_PS_SUPER]; // see RULE2
            status_nxt[`UETU_ST_MULTI_DATA:`UETU_ST_MULTI_FETCHURG] =
                3'h0; // see RULE3
        end else if (proceed & multi) begin
            status_nxt[`UETU_ST_MULTI_DATA:`UETU_ST_MULTI_FETCHURG] =
                statusR[`UETU_ST_MULTI_DATA:`UETU_ST_MULTI_FETCHURG]
                | causeSet; // see RULE3
        end
    end
    // core state, level and status flops
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            coreSt_r <= ST_EXEC;
            trapLevelR <= {LEVEL_W{1'b0}};
            haltedR <= 1'b0;
            recoveryR <= 1'b0;
            statusR <= `UETU_ST_RESET;
        end else begin
            coreSt_r <= coreSt_nxt;
            trapLevelR <= level_nxt;
            haltedR <= (coreSt_nxt == ST_HALT);
            recoveryR <= (coreSt_nxt == ST_RECOV);
            statusR <= status_nxt;
        end
    end
    // handler and weak flags; a set wins over a same-cycle clear
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            handlerActiveR <= 1'b0;
            weakDetectR <= 1'b0;
        end else begin
            if (proceed & single) begin
                handlerActiveR <= 1'b1; // see RULE19
            end else if (retireReturn) begin
                handlerActiveR <= 1'b0; // see RULE21
            end
            if (proceed & multi) begin
                weakDetectR <= 1'b1; // see RULE20
            end else if (weakClr) begin
                weakDetectR <= 1'b0;
            end
        end
    end
    // trap side effects, one cycle after the strobe
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            trapTakenR <= 1'b0;
            pcR <= 64'h0000_0000_0000_0000;
            npcR <= 64'h0000_0000_0000_0000;
            stateR <= 13'h0000;
            savedStateR <= 13'h0000;
            savedStateFaultR <= 1'b0;
            savedPcR <= 64'h0000_0000_0000_0000;
            savedPcFaultR <= 1'b0;
            savedNpcR <= 64'h0000_0000_0000_0000;
            savedNpcFaultR <= 1'b0;
            ccrZeroR <= 1'b0;
            fsrZeroR <= 1'b0;
            gsrZeroR <= 1'b0;
            winZeroR <= 5'h00;
            tickWrR <= 1'b0;
            tickNewR <= 64'h0000_0000_0000_0000;
            cmpWrR <= 1'b0;
            cmpNewR <= 64'h0000_0000_0000_0000;
        end else begin
            trapTakenR <= proceed;
            ccrZeroR <= proceed & ccrFault; // see RULE13
            fsrZeroR <= proceed & fsrFault;
            gsrZeroR <= proceed & gsrFault;
            winZeroR <= {5{proceed}} & winFault; // see RULE14
            // a full rewrite regenerates parity, see RULE16
            tickWrR <= proceed & tickFault; // see RULE15
            cmpWrR <= proceed & cmpFault;
            if (proceed) begin
                pcR <= target; // see RULE12
                npcR <= target + `UETU_NPC_STEP;
                stateR <= newState; // see RULE11
                savedStateR <= curState; // see RULE10
                savedStateFaultR <= curStateFault;
                savedPcR <= curPc;
                savedPcFaultR <= curPcFault;
                savedNpcR <= curNpc;
                savedNpcFaultR <= curNpcFault;
                tickNewR <= `UETU_TICK_NPT_SET; // see RULE15
                cmpNewR <= `UETU_CMP_DIS_SET;
            end
        end
    end
endmodule
